/* File: rtl/fabi_pkg.sv */
// Shared constants and types for the flash asynchronous bus interface.
// Assumes both ends run on one CORE_CLK with strobes sampled synchronously.
package fabi_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int PAGE_SEL_W = 2;
  localparam int PAGE_WORDS = 4;
  // Access times, ns, and cycle counts at 200 MHz
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_ACC_NS = 90;
  localparam int T_PAGE_NS = 25;
  localparam int T_IDLE_NS = 200;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_CYC = (T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC = (T_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic READ_SEL_RST = 1'b1;
  // Read sources selected by command state
  typedef enum logic [2:0] {
    FABI_SRC_ARRAY = 3'h0,
    FABI_SRC_SIG = 3'h1,
    FABI_SRC_STATUS = 3'h2,
    FABI_SRC_QUERY = 3'h3,
    FABI_SRC_PROT = 3'h4
  } fabi_src_type;
  typedef enum logic [3:0] {
    FABI_H_IDLE = 4'b0001,
    FABI_H_ASSERT = 4'b0010,
    FABI_H_WAIT = 4'b0100,
    FABI_H_RELEASE = 4'b1000
  } fabi_hstate_type;
endpackage : fabi_pkg

/* File: rtl/fabi_if.sv */
// Pin bundle between host and flash ends of the asynchronous bus.
// Assumes data_bus is resolved here from the two output enables.
`timescale 1ns/1ps
interface fabi_if;
  import fabi_pkg::*;
  logic [ADDR_W-1:0] addr_bus;
  logic [DATA_W-1:0] dq_host_o;
  logic dq_host_oe;
  logic [DATA_W-1:0] dq_dev_o;
  logic dq_dev_oe;
  logic [DATA_W-1:0] data_bus;
  logic cs_n;
  logic oe_n;
  logic store_strobe_n;
  logic adv_n;
  logic rst_pd_n;
  logic bus_clk;
  // Undriven bus shows the inverse of the host word
  assign data_bus = dq_dev_oe ? dq_dev_o :
    (dq_host_oe ? dq_host_o : ~dq_host_o);
  modport dev (input addr_bus, dq_host_o, cs_n, oe_n, store_strobe_n,
    adv_n, rst_pd_n, bus_clk, data_bus, output dq_dev_o, dq_dev_oe);
  modport host (output addr_bus, dq_host_o, dq_host_oe, cs_n, oe_n,
    store_strobe_n, adv_n, rst_pd_n, bus_clk, input dq_dev_o, data_bus);
endinterface : fabi_if

/* File: rtl/fabi_timer.sv */
// Down counter giving an access-time done flag.
// Assumes load and count come from the flash end on the same clock.
`timescale 1ns/1ps
module fabi_timer
  import fabi_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic load, // Restart count
  input wire logic [CNT_W-1:0] value, // Cycles to wait
  output logic done // Count expired
);
  logic [CNT_W-1:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= '0;
    else if (load) cnt_q <= value;
    else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
  end
  assign done = (cnt_q == '0) && !load;
endmodule : fabi_timer

/* File: rtl/fabi_dev.sv */
// Flash end of the asynchronous parallel host port.
// Assumes strobes from the host are synchronous to CORE_CLK.
`timescale 1ns/1ps
module fabi_dev
  import fabi_pkg::*;
#(
  parameter int MEM_DEPTH = 64
)(
  input wire logic CORE_CLK, // System clock
  input wire logic NRST, // Async reset, low
  fabi_if.dev BUS, // Pin bundle
  output logic [ADDR_W-1:0] CMD_ADDR, // Command address
  output logic [DATA_W-1:0] CMD_DATA, // Command data
  output logic CMD_VALID, // Write pulse
  input wire logic [2:0] READ_SRC, // Read source select
  input wire logic [DATA_W-1:0] REG_RDATA, // Register read data
  input wire logic PE_BUSY, // Program/erase active
  input wire logic READ_SEL_WR, // Load read-select bit
  input wire logic READ_SEL_VAL, // New read-select value
  output logic READ_SEL, // Read-select bit
  output logic LOW_POWER, // Auto low power
  output logic STANDBY, // Standby state
  output logic PE_CURRENT, // Program/erase current
  output logic POWER_DOWN // Power-down state
);
  localparam int MEM_AW = $clog2(MEM_DEPTH);
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [ADDR_W-1:0] lat_q, wa_q, page_q;
  logic adv_q, cs_q, we_q, wa_held_q, page_ok_q;
  logic [DATA_W-1:0] dout_q;
  logic oe_out_q, rd_sel_q, lp_q, sb_q, pe_q, pd_q;
  logic [CNT_W-1:0] idle_q;
  logic [ADDR_W-1:0] cmd_a_q;
  logic [DATA_W-1:0] cmd_d_q;
  logic cmd_v_q;
  logic oe_seen_q;
  logic [ADDR_W-1:0] addr_seen_q;

  function automatic logic edge_up(input logic now_lvl, input logic was_lvl);
    return now_lvl && !was_lvl;
  endfunction : edge_up

  wire active = BUS.rst_pd_n;
  wire sel = active && !BUS.cs_n;
  // Transparent when adv_n low, else held
  wire [ADDR_W-1:0] eff_addr = !BUS.adv_n ? BUS.addr_bus : lat_q;
  wire adv_rise = edge_up(BUS.adv_n, adv_q);
  wire cs_rise = edge_up(BUS.cs_n, cs_q);
  wire we_rise = edge_up(BUS.store_strobe_n, we_q);
  wire wr_end = active && (cs_rise || we_rise) && !we_q;
  wire wr_cyc = sel && !BUS.store_strobe_n;
  // Write address: first of adv/cs/we rising
  wire [ADDR_W-1:0] wr_addr = wa_held_q ? wa_q : eff_addr;
  wire rd_cyc = sel && BUS.store_strobe_n && !BUS.oe_n && BUS.adv_n;
  wire rd_plain = sel && BUS.store_strobe_n && !BUS.oe_n && !BUS.adv_n;
  wire reading = rd_cyc || rd_plain;
  wire same_page = eff_addr[ADDR_W-1:PAGE_SEL_W] ==
    page_q[ADDR_W-1:PAGE_SEL_W];
  wire [CNT_W-1:0] acc_val = (page_ok_q && same_page) ? CNT_W'(PAGE_CYC)
    : CNT_W'(ACC_CYC);
  wire addr_chg = eff_addr != page_q;
  wire start_acc = reading && (addr_chg || !page_ok_q);
  wire acc_done;
  wire [DATA_W-1:0] rd_word = (READ_SRC == FABI_SRC_ARRAY) ?
    mem[eff_addr[MEM_AW-1:0]] : REG_RDATA;
  // Any strobe or address pin movement restarts the idle count
  wire bus_moved = (BUS.adv_n != adv_q) || (BUS.cs_n != cs_q) ||
    (BUS.store_strobe_n != we_q) || (BUS.oe_n != oe_seen_q) ||
    (BUS.addr_bus != addr_seen_q);
  wire bus_quiet = reading && !bus_moved && rd_sel_q;
  // Array changes only when the program controller finishes
  wire prog_done = pe_q && !PE_BUSY;

  fabi_timer u_timer (
    .clk(CORE_CLK),
    .rst_n(NRST),
    .load(start_acc),
    .value(acc_val),
    .done(acc_done)
  );

  // Pin history for edges and idle detection
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      adv_q <= 1'b1;
      cs_q <= 1'b1;
      we_q <= 1'b1;
      oe_seen_q <= 1'b1;
      addr_seen_q <= '0;
    end else begin
      adv_q <= BUS.adv_n;
      cs_q <= BUS.cs_n;
      we_q <= BUS.store_strobe_n;
      oe_seen_q <= BUS.oe_n;
      addr_seen_q <= BUS.addr_bus;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) lat_q <= '0;
    else if (!active) lat_q <= '0;
    else if (!BUS.adv_n) lat_q <= BUS.addr_bus;
  end

  // Write capture; bus_clk never consulted
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_a_q <= '0;
      cmd_d_q <= '0;
      cmd_v_q <= 1'b0;
    end else begin
      cmd_v_q <= wr_end;
      if (wr_end) begin
        cmd_a_q <= wr_addr;
        cmd_d_q <= BUS.data_bus;
      end
    end
  end

  // Address of a latched write, held until cs_n or the write strobe rises
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wa_q <= '0;
      wa_held_q <= 1'b0;
    end else if (!active || wr_end) begin
      wa_held_q <= 1'b0;
    end else if (wr_cyc && adv_rise && !wa_held_q) begin
      wa_q <= lat_q;
      wa_held_q <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (prog_done && cmd_a_q[ADDR_W-1:MEM_AW] == '0)
      mem[cmd_a_q[MEM_AW-1:0]] <= cmd_d_q;
  end

  // Read path with page timing
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      page_q <= '0;
      page_ok_q <= 1'b0;
      dout_q <= '0;
      oe_out_q <= 1'b0;
    end else begin
      if (start_acc) begin
        page_q <= eff_addr;
        page_ok_q <= 1'b1;
      end
      if (!reading) page_ok_q <= 1'b0;
      oe_out_q <= reading && acc_done;
      if (reading && acc_done) dout_q <= rd_word;
    end
  end

  // Read mode and automatic low power
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_sel_q <= READ_SEL_RST;
      idle_q <= '0;
      lp_q <= 1'b0;
    end else begin
      if (!active) rd_sel_q <= READ_SEL_RST;
      else if (READ_SEL_WR) rd_sel_q <= READ_SEL_VAL;
      if (!bus_quiet) idle_q <= '0;
      else if (idle_q != CNT_W'(IDLE_CYC)) idle_q <= idle_q + 1'b1;
      lp_q <= bus_quiet && idle_q == CNT_W'(IDLE_CYC);
    end
  end

  // Power states
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sb_q <= 1'b0;
      pe_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      sb_q <= active && BUS.cs_n;
      pe_q <= PE_BUSY && active;
      pd_q <= !active;
    end
  end

  assign BUS.dq_dev_o = dout_q;
  assign BUS.dq_dev_oe = oe_out_q;
  assign CMD_ADDR = cmd_a_q;
  assign CMD_DATA = cmd_d_q;
  assign CMD_VALID = cmd_v_q;
  assign READ_SEL = rd_sel_q;
  assign LOW_POWER = lp_q;
  assign STANDBY = sb_q;
  assign PE_CURRENT = pe_q;
  assign POWER_DOWN = pd_q;
endmodule : fabi_dev

/* File: rtl/fabi_host.sv */
// Host end: drives latched reads and latched writes on the pin bundle.
// Assumes one request at a time, issued while BUSY is low.
`timescale 1ns/1ps
module fabi_host
  import fabi_pkg::*;
#(
  parameter int HOLD_CYC = 24
)(
  input wire logic CORE_CLK, // System clock
  input wire logic NRST, // Async reset, low
  fabi_if.host BUS, // Pin bundle
  input wire logic REQ, // Start a transfer
  input wire logic REQ_WRITE, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] REQ_ADDR, // Word address
  input wire logic [DATA_W-1:0] REQ_WDATA, // Write data
  input wire logic PD_REQ, // Hold flash powered down
  output logic BUSY, // Transfer in progress
  output logic [DATA_W-1:0] RDATA, // Read data
  output logic RVALID // Read data pulse
);
  fabi_hstate_type st_q, st_d;
  logic [CNT_W-1:0] cnt_q;
  logic wr_q, cs_q, oe_q, we_q, adv_q, pd_q, rv_q, hoe_q;
  logic busy_q;
  logic [ADDR_W-1:0] a_q;
  logic [DATA_W-1:0] wd_q, rd_q;
  wire cnt_end = cnt_q == CNT_W'(HOLD_CYC);
  always_comb begin
    st_d = st_q;
    case (st_q)
      FABI_H_IDLE: if (REQ && !pd_q) st_d = FABI_H_ASSERT;
      FABI_H_ASSERT: st_d = FABI_H_WAIT;
      FABI_H_WAIT: if (cnt_end) st_d = FABI_H_RELEASE;
      FABI_H_RELEASE: st_d = FABI_H_IDLE;
      default: st_d = FABI_H_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= FABI_H_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      a_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      rv_q <= 1'b0;
      cs_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      adv_q <= 1'b1;
      hoe_q <= 1'b0;
      pd_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_q <= st_d != FABI_H_IDLE;
      pd_q <= PD_REQ;
      rv_q <= 1'b0;
      cnt_q <= (st_q == FABI_H_WAIT) ? cnt_q + 1'b1 : '0;
      if (st_q == FABI_H_IDLE && st_d == FABI_H_ASSERT) begin
        wr_q <= REQ_WRITE;
        a_q <= REQ_ADDR;
        wd_q <= REQ_WDATA;
        cs_q <= 1'b0;
        adv_q <= 1'b0;
        we_q <= !REQ_WRITE;
        hoe_q <= REQ_WRITE;
      end
      if (st_q == FABI_H_ASSERT) begin
        adv_q <= 1'b1;
        oe_q <= wr_q;
      end
      if (st_q == FABI_H_WAIT && cnt_end) begin
        we_q <= 1'b1;
        cs_q <= 1'b1;
        oe_q <= 1'b1;
        if (!wr_q) begin
          rd_q <= BUS.data_bus;
          rv_q <= 1'b1;
        end
      end
      if (st_q == FABI_H_RELEASE) hoe_q <= 1'b0;
    end
  end
  assign BUS.addr_bus = a_q;
  assign BUS.dq_host_o = wd_q;
  assign BUS.dq_host_oe = hoe_q;
  assign BUS.cs_n = cs_q;
  assign BUS.oe_n = oe_q;
  assign BUS.store_strobe_n = we_q;
  assign BUS.adv_n = adv_q;
  assign BUS.rst_pd_n = !pd_q;
  assign BUS.bus_clk = 1'b0;
  assign BUSY = busy_q;
  assign RDATA = rd_q;
  assign RVALID = rv_q;
endmodule : fabi_host

/* File: tb/fabi_monitor.sv */
// Checker on the pin bundle between the host and flash ends.
// Assumes it sits beside the bundle, sampling the strobes and device data on CORE_CLK.
`timescale 1ns/1ps
module fabi_monitor
  import fabi_pkg::*;
(
  input wire logic CORE_CLK, // Clock
  input wire logic NRST, // Async reset, low
  input wire logic [DATA_W-1:0] dq_dev_o, // Device data
  input wire logic dq_dev_oe, // Device drive
  input wire logic cs_n, // Chip select
  input wire logic oe_n, // Output enable
  input wire logic store_strobe_n, // Write strobe
  input wire logic adv_n, // Address latch
  input wire logic rst_pd_n // Power-down
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  sequence rd_start;
    $fell(oe_n) && !cs_n && rst_pd_n;
  endsequence
  sequence data_up;
    (!dq_dev_oe)[*8] ##[11:14] $rose(dq_dev_oe);
  endsequence
  a_float_oe_high: assert property (oe_n && $past(oe_n) |-> !dq_dev_oe)
    else $error("data driven with output enable high");
  a_float_standby: assert property (cs_n && $past(cs_n) |-> !dq_dev_oe)
    else $error("data driven in standby");
  a_float_pdown: assert property (!rst_pd_n && !$past(rst_pd_n) |->
    !dq_dev_oe)
    else $error("data driven in power-down");
  a_write_oe_high: assert property (!store_strobe_n |-> oe_n)
    else $error("output enable low during write");
  a_latch_first: assert property ($fell(oe_n) |-> adv_n)
    else $error("output enabled before address latched");
  a_access_time: assert property (rd_start |-> data_up)
    else $error("first access time wrong");
  a_no_early_data: assert property ($rose(dq_dev_oe) |->
    $past(!oe_n && !cs_n, 5))
    else $error("data driven before page access time");
  a_data_stable: assert property (dq_dev_oe && $past(dq_dev_oe) |->
    $stable(dq_dev_o))
    else $error("read data changed while driven");
endmodule : fabi_monitor

/* File: tb/fabi_bench.sv */
// Bench: host and flash ends joined by one bundle, driven from user sides.
// Assumes the design package; 200 MHz clock and a 3-cycle reset.
`timescale 1ns/1ps
module fabi_bench;
  import fabi_pkg::*;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic pd_req = 1'b0;
  logic [2:0] read_src = 3'h0;
  logic [DATA_W-1:0] reg_rdata = '0;
  logic pe_busy = 1'b0;
  logic rs_wr = 1'b0;
  logic rs_val = 1'b1;
  logic busy, rvalid, cmd_valid, read_sel, low_power, standby;
  logic pe_current, power_down, lp;
  logic [DATA_W-1:0] rdata, cmd_data;
  logic [ADDR_W-1:0] cmd_addr;
  int miscompares = 0;
  int comparisons = 0;
  int s;
  always #2.5 CORE_CLK = ~CORE_CLK;
  fabi_if bus_if();
  fabi_host #(.HOLD_CYC(64)) i_fabi_host (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .BUS(bus_if), .REQ(req), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .PD_REQ(pd_req), .BUSY(busy), .RDATA(rdata),
    .RVALID(rvalid));
  fabi_dev i_fabi_dev (.CORE_CLK(CORE_CLK), .NRST(NRST), .BUS(bus_if),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_VALID(cmd_valid),
    .READ_SRC(read_src), .REG_RDATA(reg_rdata), .PE_BUSY(pe_busy),
    .READ_SEL_WR(rs_wr), .READ_SEL_VAL(rs_val), .READ_SEL(read_sel),
    .LOW_POWER(low_power), .STANDBY(standby), .PE_CURRENT(pe_current),
    .POWER_DOWN(power_down));
  fabi_monitor i_fabi_monitor (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .dq_dev_o(bus_if.dq_dev_o), .dq_dev_oe(bus_if.dq_dev_oe),
    .cs_n(bus_if.cs_n), .oe_n(bus_if.oe_n),
    .store_strobe_n(bus_if.store_strobe_n), .adv_n(bus_if.adv_n),
    .rst_pd_n(bus_if.rst_pd_n));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic hang;
    miscompares++;
    report_and_stop();
  endtask : hang
  // One host transfer; notes low power seen while data is driven
  task automatic host_op(input logic w, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
    int n;
    for (n = 0; busy !== 1'b0; n++) begin
      if (n == 200) hang();
      @(negedge CORE_CLK);
    end
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge CORE_CLK);
    req = 1'b0;
    lp = 1'b0;
    for (n = 0; (w ? cmd_valid : rvalid) !== 1'b1; n++) begin
      if (n == 300) hang();
      lp = lp | (low_power & bus_if.dq_dev_oe);
      @(negedge CORE_CLK);
    end
    if (w) begin
      chk(32'(cmd_addr), 32'(a));
      chk(32'(cmd_data), 32'(d));
    end else begin
      chk(32'(rdata), 32'(d));
    end
  endtask : host_op
  initial begin
    repeat (3) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    NRST = 1'b1;
    @(negedge CORE_CLK);
    chk(32'(read_sel), 32'h1);
    chk(32'(standby), 32'h1);
    for (s = 0; s < 3; s++) begin
      host_op(1'b1, 21'(21'h1fffff * (s & 1)), 16'(16'h5a5a ^ s));
    end
    $display("test write done");
    for (s = 1; s < 5; s++) begin
      read_src = 3'(s);
      reg_rdata = 16'(s * 16'h1357);
      host_op(1'b0, 21'(s * 8), reg_rdata);
      chk(32'(lp), 32'h1);
    end
    $display("test read done");
    repeat (2) @(negedge CORE_CLK);
    chk(32'(standby), 32'h1);
    pe_busy = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    chk(32'(pe_current), 32'h1);
    pe_busy = 1'b0;
    rs_wr = 1'b1;
    rs_val = 1'b0;
    @(negedge CORE_CLK);
    rs_wr = 1'b0;
    @(negedge CORE_CLK);
    chk(32'(read_sel), 32'h0);
    read_src = 3'h0;
    host_op(1'b0, 21'h0, 16'h5a58);
    chk(32'(lp), 32'h0);
    $display("test array read done");
    pd_req = 1'b1;
    repeat (4) @(negedge CORE_CLK);
    chk(32'(power_down), 32'h1);
    chk(32'(read_sel), 32'h1);
    req = 1'b1;
    req_write = 1'b1;
    @(negedge CORE_CLK);
    req = 1'b0;
    lp = 1'b0;
    repeat (40) begin
      lp = lp | cmd_valid;
      @(negedge CORE_CLK);
    end
    chk(32'(lp), 32'h0);
    pd_req = 1'b0;
    $display("test power-down done");
    report_and_stop();
  end
endmodule : fabi_bench
